// ### bench/sepp_port_chk.sv
/*
  checker for the serial program port.
  assumes a pin clock high and low at least 4 clk_i each.
*/
`timescale 1ns/10ps
`default_nettype none
module sepp_port_chk (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic master_clear_pin_i,
  input wire logic prog_clock_pin_i,
  input wire logic prog_data_pin_i,
  input wire logic prog_data_pin_o,
  input wire logic prog_data_pin_oe_o,
  input wire logic prog_active_o,
  input wire sepp_pkg::sepp_pc_t pc_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // pin clock edge seen a few cycles back
  sequence rose_late;
    $past(prog_clock_pin_i, 2) && !$past(prog_clock_pin_i, 6);
  endsequence
  sequence fell_late;
    !$past(prog_clock_pin_i, 2) && $past(prog_clock_pin_i, 6);
  endsequence
  a_master_clear_pin_clears: assert property (!master_clear_pin_i [*6] |->
    pc_o == 14'h0 && !prog_active_o && !prog_data_pin_oe_o) else $error("state kept");
  a_cfg_sticky: assert property ((master_clear_pin_i && pc_o[13]) [*4] |=>
    pc_o[13]) else $error("config space left");
  a_pc_step: assert property ($changed(pc_o) |-> pc_o == $past(pc_o) + 14'h1 ||
    pc_o == 14'h2000 || pc_o == 14'h0) else $error("bad counter step");
  a_pc_on_fall: assert property ($changed(pc_o) && master_clear_pin_i |->
    fell_late) else $error("counter moved off a falling edge");
  a_oe_on_rise: assert property ($changed(prog_data_pin_oe_o) && master_clear_pin_i |->
    rose_late) else $error("enable moved off a rising edge");
  a_dout_on_rise: assert property ($changed(prog_data_pin_o) && prog_data_pin_oe_o |->
    rose_late) else $error("data moved off a rising edge");
  a_act_on_fall: assert property ($changed(prog_active_o) && master_clear_pin_i |->
    fell_late) else $error("programming moved off a falling edge");
  a_idle_no_drive: assert property (!prog_clock_pin_i [*8] |->
    !prog_data_pin_oe_o) else $error("pin driven while idle");
endmodule : sepp_port_chk
bind sepp_port sepp_port_chk i_chk (.clk_i, .sys_rst_i, .master_clear_pin_i,
  .prog_clock_pin_i, .prog_data_pin_i, .prog_data_pin_o, .prog_data_pin_oe_o,
  .prog_active_o, .pc_o);
`default_nettype wire

// ### bench/sepp_prog_model.sv
/*
  programmer model: drives pin clock and data, shifts frames both ways.
  assumes the bench resolves the shared data wire.
*/
`timescale 1ns/10ps
`default_nettype none
module sepp_prog_model (
  input wire logic pin_i,
  output logic clk_o,
  output logic dat_o
);
  // pin clock idles low between transfers
  initial begin
    clk_o = 1'b0;
    dat_o = 1'b0;
  end
  // one 320 ns cycle, bit held 120 ns past the fall
  task automatic cyc(input logic b, output logic s);
    dat_o = b;
    #40 clk_o = 1'b1;
    #160 clk_o = 1'b0;
    #80 s = pin_i;
    #40;
  endtask : cyc
  // six-bit command, unused bits vary with the code
  task automatic cmd(input logic [2:0] code);
    logic [5:0] w;
    logic s;
    w = {code[0], ~code[1], code, code[2]};
    for (int i = 0; i < 6; i++) cyc(w[i], s);
    dat_o = 1'b0;
    #1000;
  endtask : cmd
  // framed word, toggling pattern while the device drives
  task automatic frame(input logic [13:0] wr, output logic [13:0] rd);
    logic [15:0] f;
    logic s;
    f = {1'b0, wr, 1'b0};
    for (int i = 0; i < 16; i++) begin
      cyc(f[i], s);
      if (i > 0 && i < 15) rd[i-1] = s;
    end
    #1000;
  endtask : frame
endmodule : sepp_prog_model
`default_nettype wire

// ### bench/testbench.sv
/*
  testbench for the serial program port.
  assumes the programmer model and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sepp_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic master_clear = 1'b0;
  logic pclk, pdat, dout, oe, act, pin;
  sepp_pc_t pc;
  sepp_word_t rd;
  int miscompares = 0;
  int checks = 0;
  always #20 clk_i = ~clk_i;
  // shared data wire
  assign pin = oe ? dout : pdat;
  sepp_port i_sepp_port (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .master_clear_pin_i(master_clear), .prog_clock_pin_i(pclk), .prog_data_pin_i(pin),
    .prog_data_pin_o(dout), .prog_data_pin_oe_o(oe), .prog_active_o(act), .pc_o(pc));
  sepp_prog_model i_sepp_prog_model (.pin_i(pin), .clk_o(pclk), .dat_o(pdat));
  task automatic chk(input string n, input sepp_word_t e, input sepp_word_t g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // mode entry or exit with clock and data low
  task automatic mode(input logic v);
    @(posedge clk_i);
    #1 master_clear = v;
    repeat (8) @(posedge clk_i);
    #1;
  endtask : mode
  // load, one 100 us pulse
  task automatic prog(input logic [2:0] ld, input sepp_word_t w);
    i_sepp_prog_model.cmd(ld);
    i_sepp_prog_model.frame(w, rd);
    i_sepp_prog_model.cmd(3'h4);
    chk("active", 14'h1, {13'h0, act});
    #100000 i_sepp_prog_model.cmd(3'h7);
    chk("active", 14'h0, {13'h0, act});
  endtask : prog
  task automatic rdw(input sepp_word_t e);
    i_sepp_prog_model.cmd(3'h2);
    i_sepp_prog_model.frame(14'h1555, rd);
    chk("read", e, rd);
    chk("oe", 14'h0, {13'h0, oe});
  endtask : rdw
  task automatic t_user;
    mode(1'b1);
    chk("pc", 14'h0, pc);
    prog(3'h1, 14'h2a5c);
    i_sepp_prog_model.cmd(3'h3);
    chk("pc", 14'h1, pc);
    prog(3'h1, 14'h15a3);
    i_sepp_prog_model.cmd(3'h5);
    i_sepp_prog_model.cmd(3'h6);
    chk("pc", 14'h1, pc);
    mode(1'b0);
    mode(1'b1);
    rdw(14'h2a5c);
    i_sepp_prog_model.cmd(3'h3);
    rdw(14'h15a3);
    $display("user memory test done");
  endtask : t_user
  task automatic t_cfg;
    i_sepp_prog_model.cmd(3'h3);
    prog(3'h0, 14'h3e01);
    chk("pc", 14'h2000, pc);
    rdw(14'h3e01);
    i_sepp_prog_model.cmd(3'h3);
    chk("pc", 14'h2001, pc);
    i_sepp_prog_model.cmd(3'h1);
    i_sepp_prog_model.frame(14'h0123, rd);
    chk("pc", 14'h2001, pc);
    mode(1'b0);
    chk("pc", 14'h0, pc);
    mode(1'b1);
    rdw(14'h2a5c);
    mode(1'b0);
    $display("config memory test done");
  endtask : t_cfg
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  // reset, then the scenarios
  initial begin
    repeat (16) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    chk("pc", 14'h0, pc);
    t_user();
    t_cfg();
    test_done();
  end
  // watchdog, about five times the expected run
  initial begin
    #2000000;
    miscompares++;
    test_done();
  end
endmodule : testbench
`default_nettype wire

// ### hw/sepp_consts.svh
/*
  Constants for the serial program port: command codes, frame lengths, address map.
  Assumes inclusion by the package and the design modules only.
*/
`ifndef SEPP_CONSTS_SVH
`define SEPP_CONSTS_SVH
`define SEPP_CMD_BITS 6
`define SEPP_FRAME_BITS 16
`define SEPP_WORD_BITS 14
`define SEPP_PC_BITS 14
`define SEPP_CODE_LOAD_CFG 3'h0
`define SEPP_CODE_LOAD_DATA 3'h1
`define SEPP_CODE_READ 3'h2
`define SEPP_CODE_INC 3'h3
`define SEPP_CODE_BEGIN 3'h4
`define SEPP_CODE_END 3'h7
`define SEPP_CFG_BASE 14'h2000
`define SEPP_USER_BASE 14'h0000
`define SEPP_CFG_BIT 13
`define SEPP_CODE_LSB 1
`define SEPP_CODE_MSB 3
`define SEPP_DATA_FIRST 5'h01
`define SEPP_DATA_LAST 5'h0e
`define SEPP_FRAME_LAST 5'h0f
`define SEPP_CMD_LAST 5'h05
`define SEPP_MEM_AW 10
`endif

// ### hw/sepp_mem.sv
/*
  Small word memory standing in for the EPROM array, registered read data.
  Assumes one clock, writes and reads on the same edge stay independent.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sepp_consts.svh"
module sepp_mem #(
  parameter int AW = `SEPP_MEM_AW,
  parameter int DW = `SEPP_WORD_BITS
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  // write port and registered read port
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : sepp_mem
`default_nettype wire

// ### hw/sepp_pkg.sv
/*
  Types for the serial program port.
  Assumes sepp_consts.svh is on the include path.
*/
`include "sepp_consts.svh"
package sepp_pkg;
  typedef logic [`SEPP_WORD_BITS-1:0] sepp_word_t;
  typedef logic [`SEPP_PC_BITS-1:0] sepp_pc_t;
  typedef enum logic [1:0] {SEPP_CMD, SEPP_LOAD, SEPP_READ} sepp_phase_t;
endpackage : sepp_pkg

// ### hw/sepp_port.sv
/*
  Serial program/verify port: 6-bit commands, 16-cycle data frames, lsb first.
  Assumes the programmer clock and data pins are asynchronous to clk_i and
  far slower (clock period well above 8 system cycles); high-voltage entry arrives as a level.
*/
// How it works
// - every command is six programmer clock cycles
// - command bits captured on falling clock edges, lsb first
// - data frame is 16 cycles: start bit, data, stop bit
// - data words travel lsb first both directions
// - read lsb driven on rising edge of second frame cycle
// - load lsb captured on falling edge of second frame cycle
// - load configuration sets counter to 2000h, then loads a word
// - configuration space is kept until master clear drops
// - load data takes a 14-bit word from the next frame
// - read drives pin from second rising edge, releases after sixteenth
// - increment address advances counter, no frame follows
// - only command bits 3..1 decode; six codes defined
// - begin programming starts writing the addressed word
// - end programming stops the write in progress
// - counter wraps inside configuration space to 2000h
`timescale 1ns/10ps
`default_nettype none
`include "sepp_consts.svh"
module sepp_port (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic master_clear_pin_i,
  input wire logic prog_clock_pin_i,
  input wire logic prog_data_pin_i,
  output logic prog_data_pin_o,
  output logic prog_data_pin_oe_o,
  output logic prog_active_o,
  output sepp_pkg::sepp_pc_t pc_o
);
  import sepp_pkg::*;

  // two-stage synchronisers for the pins
  logic [1:0] master_clear_pin_s, clk_s, dat_s;
  logic clk_d;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      master_clear_pin_s <= 2'h0;
      clk_s <= 2'h0;
      dat_s <= 2'h0;
      clk_d <= 1'b0;
    end else begin
      master_clear_pin_s <= {master_clear_pin_s[0], master_clear_pin_i};
      clk_s <= {clk_s[0], prog_clock_pin_i};
      dat_s <= {dat_s[0], prog_data_pin_i};
      clk_d <= clk_s[1];
    end
  end

  logic in_mode, rise, fall, din;
  assign in_mode = master_clear_pin_s[1];
  assign rise = clk_s[1] & ~clk_d;
  assign fall = ~clk_s[1] & clk_d;
  assign din = dat_s[1];

  // next counter value with configuration-space wrap
  function automatic sepp_pc_t pc_inc(input sepp_pc_t pc);
    sepp_pc_t n;
    n = pc + 14'h0001;
    if (pc[`SEPP_CFG_BIT]) begin
      n[`SEPP_CFG_BIT] = 1'b1;
    end
    return n;
  endfunction : pc_inc

  // protocol state
  sepp_phase_t phase, next_phase;
  logic [4:0] cnt, next_cnt;
  logic [`SEPP_CMD_BITS-1:0] cmd_sh, next_cmd_sh;
  sepp_word_t word, next_word;
  sepp_word_t latch, next_latch;
  sepp_pc_t pc, next_pc;
  logic prog, next_prog;
  logic dout, next_dout;
  logic oe, next_oe;
  logic we;
  logic [`SEPP_MEM_AW:0] maddr;
  sepp_word_t rdata;

  // space bit on top keeps configuration words apart from user words
  assign maddr = {pc[`SEPP_CFG_BIT], pc[`SEPP_MEM_AW-1:0]};
  sepp_mem #(.AW(`SEPP_MEM_AW + 1), .DW(`SEPP_WORD_BITS)) u_mem (
    .clk_i(clk_i),
    .we_i(we),
    .waddr_i(maddr),
    .wdata_i(latch),
    .raddr_i(maddr),
    .rdata_o(rdata)
  );

  // write pulses land while programming is on; held word is rewritten each cycle
  assign we = prog & in_mode;

  // next-state logic
  always_comb begin
    logic [2:0] code;
    code = 3'h0;
    next_phase = phase;
    next_cnt = cnt;
    next_cmd_sh = cmd_sh;
    next_word = word;
    next_latch = latch;
    next_pc = pc;
    next_prog = prog;
    next_dout = dout;
    next_oe = oe;
    if (!in_mode) begin
      // out of mode: everything but word and latch cleared, pin released
      next_phase = SEPP_CMD;
      next_cnt = 5'h00;
      next_cmd_sh = '0;
      next_pc = `SEPP_USER_BASE;
      next_prog = 1'b0;
      next_oe = 1'b0;
      next_dout = 1'b0;
    end else begin
      case (phase)
        SEPP_CMD: begin
          if (fall) begin
            next_cmd_sh = {din, cmd_sh[`SEPP_CMD_BITS-1:1]};
            next_cnt = cnt + 5'h01;
            if (cnt == `SEPP_CMD_LAST) begin
              next_cnt = 5'h00;
              code = next_cmd_sh[`SEPP_CODE_MSB:`SEPP_CODE_LSB];
              case (code)
                `SEPP_CODE_LOAD_CFG: begin
                  next_pc = `SEPP_CFG_BASE;
                  next_phase = SEPP_LOAD;
                end
                `SEPP_CODE_LOAD_DATA: next_phase = SEPP_LOAD;
                `SEPP_CODE_READ: begin
                  next_phase = SEPP_READ;
                  next_word = rdata;
                end
                `SEPP_CODE_INC: next_pc = pc_inc(pc);
                `SEPP_CODE_BEGIN: next_prog = 1'b1;
                `SEPP_CODE_END: next_prog = 1'b0;
                default: next_phase = SEPP_CMD;
              endcase
            end
          end
        end
        SEPP_LOAD: begin
          if (fall) begin
            next_cnt = cnt + 5'h01;
            if (cnt >= `SEPP_DATA_FIRST && cnt <= `SEPP_DATA_LAST) begin
              next_word = {din, word[`SEPP_WORD_BITS-1:1]};
            end
            if (cnt == `SEPP_FRAME_LAST) begin
              next_cnt = 5'h00;
              next_latch = word;
              next_phase = SEPP_CMD;
            end
          end
        end
        SEPP_READ: begin
          if (rise) begin
            if (cnt >= `SEPP_DATA_FIRST && cnt <= `SEPP_DATA_LAST) begin
              next_oe = 1'b1;
              next_dout = word[0];
              next_word = {1'b0, word[`SEPP_WORD_BITS-1:1]};
            end else if (cnt == `SEPP_FRAME_LAST) begin
              next_oe = 1'b0;
              next_dout = 1'b0;
            end
          end
          if (fall) begin
            next_cnt = cnt + 5'h01;
            if (cnt == `SEPP_FRAME_LAST) begin
              next_cnt = 5'h00;
              next_phase = SEPP_CMD;
            end
          end
        end
        default: next_phase = SEPP_CMD;
      endcase
    end
  end

  // register the protocol state
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase <= SEPP_CMD;
      cnt <= 5'h00;
      cmd_sh <= '0;
      word <= '0;
      latch <= '0;
      pc <= `SEPP_USER_BASE;
      prog <= 1'b0;
      dout <= 1'b0;
      oe <= 1'b0;
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
      cmd_sh <= next_cmd_sh;
      word <= next_word;
      latch <= next_latch;
      pc <= next_pc;
      prog <= next_prog;
      dout <= next_dout;
      oe <= next_oe;
    end
  end

  // outputs straight from flip-flops
  assign prog_data_pin_o = dout;
  assign prog_data_pin_oe_o = oe;
  assign prog_active_o = prog;
  assign pc_o = pc;
endmodule : sepp_port
`default_nettype wire
